// ### rtl/two_wire_pkg.sv
package two_wire_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] BUF_IDX  = 8'h13;
   localparam logic [7:0] CTL_IDX  = 8'h14;
   localparam logic [7:0] ADDR_IDX = 8'h93;
   localparam logic [7:0] STAT_IDX = 8'h94;
   localparam logic [7:0] OPT_IDX  = 8'h9e;
   localparam logic [7:0] IRQ_IDX  = 8'h0c;
   localparam int         ADR_W    = 10;
   localparam int         DAT_W    = 32;

   // serial_control fields
   localparam int CTL_WCOL = 7;
   localparam int CTL_OV   = 6;
   localparam int CTL_EN   = 5;
   localparam int CTL_CKP  = 4;
   // serial_status fields
   localparam int STAT_DA  = 5;
   localparam int STAT_P   = 4;
   localparam int STAT_S   = 3;
   localparam int STAT_RW  = 2;
   localparam int STAT_UA  = 1;
   localparam int STAT_BF  = 0;
   // port_options fields
   localparam int OPT_HOG  = 7;
   localparam int OPT_SEL  = 4;
   // irq register fields
   localparam int IRQ_FLAG = 0;
   localparam int IRQ_EN   = 1;

   // values after reset
   localparam logic [7:0] CTL_RST  = 8'h00;
   localparam logic [7:0] ADDR_RST = 8'h00;
   localparam logic [7:0] OPT_RST  = 8'h00;
   localparam logic [7:0] BUF_RST  = 8'h00;

   // port_mode_field encodings
   localparam logic [3:0] MODE_SLV7   = 4'h6;
   localparam logic [3:0] MODE_SLV10  = 4'h7;
   localparam logic [3:0] MODE_MASTER = 4'hb;

   localparam logic [4:0] TENBIT_HDR = 5'h1e;
   localparam logic [3:0] BYTE_BITS  = 4'h8;
   localparam logic [3:0] LAST_FALL  = 4'h7;

   typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK} slave_state_e;
endpackage

// ### rtl/two_wire_if.sv
// conditioned bus lines and their events
interface line_if;
   logic scl;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic start;
   logic stop;
   modport src (output scl, sda, scl_rise, scl_fall, start, stop);
   modport dst (input  scl, sda, scl_rise, scl_fall, start, stop);
endinterface

// register access strobes from the bus slave
interface reg_if;
   logic       wr;
   logic       rd;
   logic [7:0] idx;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport slv  (output wr, rd, idx, wdata, input rdata);
   modport core (input  wr, rd, idx, wdata, output rdata);
endinterface

// ### rtl/line_sync.sv
module line_sync (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic scl_raw_i,
   input  wire logic sda_raw_i,
   line_if.src       ln
);
   logic [1:0] meta_q;
   logic [1:0] sync_q;
   logic [1:0] prev_q;

   // two flops per line, then one more for edge finding
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= 2'h3;
         sync_q <= 2'h3;
         prev_q <= 2'h3;
      end else begin
         meta_q <= {sda_raw_i, scl_raw_i};
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // start and stop are data edges while the clock stays high
   assign ln.scl      = sync_q[0];
   assign ln.sda      = sync_q[1];
   assign ln.scl_rise = sync_q[0] & ~prev_q[0];
   assign ln.scl_fall = ~sync_q[0] & prev_q[0];
   assign ln.start    = sync_q[0] & prev_q[0] & ~sync_q[1] & prev_q[1];
   assign ln.stop     = sync_q[0] & prev_q[0] & sync_q[1] & ~prev_q[1];
endmodule

// ### rtl/wb_slave.sv
module wb_slave
   import two_wire_pkg::*;
(
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             cyc_i,
   input  wire logic             stb_i,
   input  wire logic             we_i,
   input  wire logic [ADR_W-1:0] adr_i,
   input  wire logic [3:0]       sel_i,
   input  wire logic [DAT_W-1:0] dat_i,
   output logic      [DAT_W-1:0] dat_o,
   output logic                  ack_o,
   reg_if.slv                    rg
);
   logic ack_q;

   // one wait state; read data captured together with ack
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_o <= '0;
      end else begin
         ack_q <= cyc_i & stb_i & ~ack_q;
         dat_o <= {24'h000000, rg.rdata};
      end
   end

   // side effects land on the edge where the master sees ack
   assign ack_o    = ack_q;
   assign rg.idx   = adr_i[9:2];
   assign rg.wdata = dat_i[7:0];
   assign rg.wr    = ack_q & cyc_i & stb_i & we_i & sel_i[0];
   assign rg.rd    = ack_q & cyc_i & stb_i & ~we_i;
endmodule

// ### rtl/two_wire_serial_port.sv
// What this block does
// - matched address or data byte: automatic acknowledge, shift register copied to buffer
// - buffer-full or overflow already set: no acknowledge, no load, interrupt still set
// - buffer read clears buffer-full; overflow cleared only by software write
// - after enable wait for start, shift eight bits sampled on clock rise
// - shift bits 7 to 1 compared with own address at eighth falling edge
// - match with flags clear: load, full, acknowledge, interrupt at ninth fall
// - ten-bit address bytes set flags, hold clock until own address rewritten
// - matched write address clears direction bit and lands in buffer
// - interrupt flag set per byte; software clears it and reads status
// - buffer-full clear from read waits out a byte being shifted in, up to its eighth fall
// - matched read address sets direction bit, acknowledges, then holds clock low
// - transmit bits change on falling clock edges, stable while clock high
// - master acknowledge latched at ninth rise; high ends transfer, wait start
// - start and stop bits cleared by reset or disable; both set interrupt
// - line with output direction is driven low regardless of port latch
// - software may take bus after stop or when idle; stop interrupts
// - master runs with slave idle (1011b) or active; software finds source
// - hold-clock option stretches clock low while receive buffer full
// - pin-pair select routes lines to port D 1:0 or port C 7:6
//
// Our own choice: the Wishbone interface to the registers.
module two_wire_serial_port
   import two_wire_pkg::*;
(
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             cyc_i,
   input  wire logic             stb_i,
   input  wire logic             we_i,
   input  wire logic [ADR_W-1:0] adr_i,
   input  wire logic [3:0]       sel_i,
   input  wire logic [DAT_W-1:0] dat_i,
   output logic      [DAT_W-1:0] dat_o,
   output logic                  ack_o,
   input  wire logic             scl_c_i,
   input  wire logic             sda_c_i,
   input  wire logic             scl_d_i,
   input  wire logic             sda_d_i,
   output logic                  scl_c_o,
   output logic                  sda_c_o,
   output logic                  scl_d_o,
   output logic                  sda_d_o,
   output logic                  scl_c_oe_o,
   output logic                  sda_c_oe_o,
   output logic                  scl_d_oe_o,
   output logic                  sda_d_oe_o,
   input  wire logic [1:0]       portc_direction_i,
   input  wire logic [1:0]       portd_direction_i,
   output logic                  irq_o
);
   line_if ln ();
   reg_if  rg ();

   slave_state_e st_q;
   logic [3:0]   cnt_q;
   logic [7:0]   shift_register;
   logic [7:0]   serial_buffer;
   logic [7:0]   own_address;
   logic [7:0]   opt_q;
   logic [3:0]   port_mode_field;
   logic         port_enable_q;
   logic         clock_release_bit;
   logic         receive_overflow_flag;
   logic         write_collision_q;
   logic         buffer_full_flag;
   logic         bf_clr_pend_q;
   logic         address_update_flag;
   logic         serial_irq_flag;
   logic         serial_irq_enable;
   logic         rw_q;
   logic         da_q;
   logic         start_seen_q;
   logic         stop_seen_q;
   logic         addr_phase_q;
   logic         byte2_q;
   logic         matched10_q;
   logic         ack_drv_q;
   logic         rd_dir_q;
   logic         nack_q;
   logic         slave_on;
   logic         ten_bit;
   logic         hold_clock_when_full;
   logic         pin_pair_select;
   logic         bf_eff;
   logic         fall8;
   logic         fall9;
   logic         txack_fall;
   logic         match;
   logic         take;
   logic         is_read;
   logic         ua_set;
   logic         load;
   logic         bf_apply;
   logic         scl_low;
   logic         sda_low;

   // registers are word aligned, index times four
   wb_slave u_bus (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .cyc_i (cyc_i),
      .stb_i (stb_i),
      .we_i  (we_i),
      .adr_i (adr_i),
      .sel_i (sel_i),
      .dat_i (dat_i),
      .dat_o (dat_o),
      .ack_o (ack_o),
      .rg    (rg)
   );

   // selected pin pair is muxed before the synchroniser
   line_sync u_sync (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .scl_raw_i (pin_pair_select ? scl_d_i : scl_c_i),
      .sda_raw_i (pin_pair_select ? sda_d_i : sda_c_i),
      .ln        (ln)
   );

   function automatic logic hit(input logic [7:0] idx);
      hit = rg.wr && (rg.idx == idx);
   endfunction

   // mode decode
   assign hold_clock_when_full = opt_q[OPT_HOG];
   assign pin_pair_select      = opt_q[OPT_SEL];
   assign ten_bit              = (port_mode_field == MODE_SLV10);
   // master-only mode keeps the slave idle
   assign slave_on = port_enable_q & ((port_mode_field == MODE_SLV7) | ten_bit);

   // a pending buffer read already counts against the overflow test
   assign bf_eff = buffer_full_flag & ~bf_clr_pend_q;
   assign fall8  = (st_q == ST_RX) && (cnt_q == BYTE_BITS) && ln.scl_fall;
   assign fall9  = (st_q == ST_ACK) && ln.scl_fall;
   assign txack_fall = (st_q == ST_TXACK) && ln.scl_fall;

   // address compare at the eighth falling edge
   always_comb begin
      match   = 1'b0;
      is_read = 1'b0;
      if (!addr_phase_q) begin
         match = 1'b1;
      end else if (!ten_bit) begin
         match   = (shift_register[7:1] == own_address[7:1]);
         is_read = shift_register[0];
      end else if (byte2_q) begin
         match = (shift_register == own_address);
      end else begin
         match   = (shift_register[7:3] == TENBIT_HDR) && (shift_register[7:1] == own_address[7:1]) &&
                   (!shift_register[0] || matched10_q);
         is_read = shift_register[0];
      end
   end

   assign take   = match & ~bf_eff & ~receive_overflow_flag;
   assign load   = fall8 & take;
   // low byte sets the update flag even without a match
   assign ua_set = fall8 & ten_bit & addr_phase_q & ~is_read & (match | byte2_q);

   // byte sequencer for the slave side
   always_ff @(posedge clk_i) begin
      if (rst_i || !slave_on) begin
         st_q         <= ST_IDLE;
         cnt_q        <= 4'h0;
         addr_phase_q <= 1'b0;
         byte2_q      <= 1'b0;
         matched10_q  <= 1'b0;
         ack_drv_q    <= 1'b0;
         rd_dir_q     <= 1'b0;
         nack_q       <= 1'b1;
      end else if (ln.start) begin
         st_q         <= ST_RX;
         cnt_q        <= 4'h0;
         addr_phase_q <= 1'b1;
         byte2_q      <= 1'b0;
      end else if (ln.stop) begin
         st_q        <= ST_IDLE;
         byte2_q     <= 1'b0;
         matched10_q <= 1'b0;
      end else begin
         case (st_q)
            ST_IDLE: begin
               cnt_q <= 4'h0;
            end
            ST_RX: begin
               if (ln.scl_rise && cnt_q != BYTE_BITS) begin
                  cnt_q <= cnt_q + 4'h1;
               end
               if (fall8) begin
                  if (!match) begin
                     st_q <= ST_IDLE;
                  end else begin
                     st_q      <= ST_ACK;
                     ack_drv_q <= take;
                     rd_dir_q  <= is_read;
                     if (addr_phase_q && ten_bit && !is_read && !byte2_q) begin
                        byte2_q <= 1'b1;
                     end else begin
                        addr_phase_q <= 1'b0;
                        byte2_q      <= 1'b0;
                        if (byte2_q) begin
                           matched10_q <= 1'b1;
                        end
                     end
                  end
               end
            end
            ST_ACK: begin
               if (ln.scl_fall) begin
                  cnt_q     <= 4'h0;
                  ack_drv_q <= 1'b0;
                  st_q      <= rd_dir_q ? ST_TX : ST_RX;
               end
            end
            ST_TX: begin
               if (ln.scl_fall) begin
                  cnt_q <= cnt_q + 4'h1;
                  if (cnt_q == LAST_FALL) begin
                     st_q <= ST_TXACK;
                  end
               end
            end
            ST_TXACK: begin
               if (ln.scl_rise) begin
                  nack_q <= ln.sda;
               end
               if (ln.scl_fall) begin
                  cnt_q <= 4'h0;
                  st_q  <= nack_q ? ST_IDLE : ST_TX;
               end
            end
            default: begin
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

   // shift register: software load wins over a bit shift
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         shift_register <= 8'h00;
      end else if (hit(BUF_IDX)) begin
         shift_register <= rg.wdata;
      end else if (st_q == ST_RX && ln.scl_rise && cnt_q != BYTE_BITS) begin
         shift_register <= {shift_register[6:0], ln.sda};
      end else if (st_q == ST_TX && ln.scl_fall) begin
         shift_register <= {shift_register[6:0], 1'b1};
      end
   end

   // receive/transmit buffer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         serial_buffer <= BUF_RST;
      end else if (load) begin
         serial_buffer <= shift_register;
      end else if (hit(BUF_IDX)) begin
         serial_buffer <= rg.wdata;
      end
   end

   // a read only arms the clear; it lands outside a byte in flight
   assign bf_apply = bf_clr_pend_q & (fall8 | (st_q != ST_RX) | (cnt_q == 4'h0));

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bf_clr_pend_q <= 1'b0;
      end else if (rg.rd && rg.idx == BUF_IDX) begin
         bf_clr_pend_q <= 1'b1;
      end else if (bf_apply) begin
         bf_clr_pend_q <= 1'b0;
      end
   end

   // buffer-full: a new load wins over the deferred clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         buffer_full_flag <= 1'b0;
      end else if (load) begin
         buffer_full_flag <= 1'b1;
      end else if (bf_apply) begin
         buffer_full_flag <= 1'b0;
      end
   end

   // overflow: set by a refused byte, cleared only by software
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         receive_overflow_flag <= 1'b0;
      end else if (fall8 && match && bf_eff) begin
         receive_overflow_flag <= 1'b1;
      end else if (hit(CTL_IDX)) begin
         receive_overflow_flag <= rg.wdata[CTL_OV];
      end
   end

   // write collision: buffer written while bits are going out
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         write_collision_q <= 1'b0;
      end else if (hit(BUF_IDX) && st_q == ST_TX && cnt_q != 4'h0) begin
         write_collision_q <= 1'b1;
      end else if (hit(CTL_IDX)) begin
         write_collision_q <= rg.wdata[CTL_WCOL];
      end
   end

   // control fields; the clock release drops on each transmit entry
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         port_enable_q     <= CTL_RST[CTL_EN];
         clock_release_bit <= CTL_RST[CTL_CKP];
         port_mode_field   <= CTL_RST[3:0];
      end else if (hit(CTL_IDX)) begin
         port_enable_q     <= rg.wdata[CTL_EN];
         clock_release_bit <= rg.wdata[CTL_CKP];
         port_mode_field   <= rg.wdata[3:0];
      end else if ((fall9 && rd_dir_q) || (txack_fall && !nack_q)) begin
         clock_release_bit <= 1'b0;
      end
   end

   // own address and option registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         own_address <= ADDR_RST;
         opt_q       <= OPT_RST;
      end else begin
         if (hit(ADDR_IDX)) begin
            own_address <= rg.wdata;
         end
         if (hit(OPT_IDX)) begin
            opt_q <= {rg.wdata[7:1], 1'b0};
         end
      end
   end

   // address update: set by hardware wins over the address rewrite
   always_ff @(posedge clk_i) begin
      if (rst_i || !slave_on) begin
         address_update_flag <= 1'b0;
      end else if (ua_set) begin
         address_update_flag <= 1'b1;
      end else if (hit(ADDR_IDX)) begin
         address_update_flag <= 1'b0;
      end
   end

   // direction and data/address status of the last matched byte
   always_ff @(posedge clk_i) begin
      if (rst_i || !slave_on) begin
         rw_q <= 1'b0;
         da_q <= 1'b0;
      end else if (fall8 && match) begin
         da_q <= ~addr_phase_q;
         if (addr_phase_q) begin
            rw_q <= is_read;
         end
      end
   end

   // start and stop seen; both forgotten while disabled
   always_ff @(posedge clk_i) begin
      if (rst_i || !port_enable_q) begin
         start_seen_q <= 1'b0;
         stop_seen_q  <= 1'b0;
      end else if (ln.start) begin
         start_seen_q <= 1'b1;
         stop_seen_q  <= 1'b0;
      end else if (ln.stop) begin
         start_seen_q <= 1'b0;
         stop_seen_q  <= 1'b1;
      end
   end

   // interrupt flag: any hardware event beats a software clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         serial_irq_flag   <= 1'b0;
         serial_irq_enable <= 1'b0;
      end else begin
         if (fall9 || txack_fall || (port_enable_q && (ln.start || ln.stop))) begin
            serial_irq_flag <= 1'b1;
         end else if (hit(IRQ_IDX)) begin
            serial_irq_flag <= rg.wdata[IRQ_FLAG];
         end
         if (hit(IRQ_IDX)) begin
            serial_irq_enable <= rg.wdata[IRQ_EN];
         end
      end
   end

   assign irq_o = serial_irq_flag & serial_irq_enable;

   // register read mux
   always_comb begin
      case (rg.idx)
         BUF_IDX:  rg.rdata = serial_buffer;
         CTL_IDX:  rg.rdata = {write_collision_q, receive_overflow_flag, port_enable_q,
                               clock_release_bit, port_mode_field};
         ADDR_IDX: rg.rdata = own_address;
         STAT_IDX: rg.rdata = {2'h0, da_q, stop_seen_q, start_seen_q, rw_q, address_update_flag,
                               buffer_full_flag};
         OPT_IDX:  rg.rdata = opt_q;
         IRQ_IDX:  rg.rdata = {6'h00, serial_irq_enable, serial_irq_flag};
         default:  rg.rdata = 8'h00;
      endcase
   end

   // clock stretch sources, each only between bytes
   assign scl_low = slave_on && (((st_q == ST_TX) && (cnt_q == 4'h0) && !clock_release_bit) ||
                    ((st_q == ST_RX) && (cnt_q == 4'h0) && addr_phase_q && byte2_q && address_update_flag) ||
                    ((st_q == ST_RX) && (cnt_q == 4'h0) && !addr_phase_q && matched10_q && address_update_flag) ||
                    ((st_q == ST_RX) && (cnt_q == 4'h0) && !addr_phase_q && hold_clock_when_full &&
                     buffer_full_flag));

   // acknowledge slot and transmit data; the line only ever goes low
   assign sda_low = slave_on && (((st_q == ST_ACK) && ack_drv_q) ||
                    ((st_q == ST_TX) && !shift_register[7]));

   // open-drain pins: direction bit low drives zero, slave adds its own pull-downs
   assign scl_c_o    = 1'b0;
   assign sda_c_o    = 1'b0;
   assign scl_d_o    = 1'b0;
   assign sda_d_o    = 1'b0;
   assign scl_c_oe_o = ~portc_direction_i[0] | (~pin_pair_select & scl_low);
   assign sda_c_oe_o = ~portc_direction_i[1] | (~pin_pair_select & sda_low);
   assign scl_d_oe_o = ~portd_direction_i[0] | (pin_pair_select & scl_low);
   assign sda_d_oe_o = ~portd_direction_i[1] | (pin_pair_select & sda_low);
endmodule

// ### sim/two_wire_serial_port_sva.sv
module twsp_sva
   import two_wire_pkg::*;
(
   input wire logic             clk_i, rst_i, cyc_i, stb_i, ack_o, scl_d_i,
   input wire logic [DAT_W-1:0] dat_o,
   input wire logic             scl_c_o, sda_c_o, scl_d_o, sda_d_o,
   input wire logic             scl_c_oe_o, sda_c_oe_o, scl_d_oe_o, sda_d_oe_o,
   input wire logic [1:0]       portc_direction_i, portd_direction_i
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [3:0] hi_q;
   // cycles the clock line has stayed high, saturating
   always_ff @(posedge clk_i) begin
      if (rst_i || !scl_d_i) hi_q <= 4'h0;
      else if (hi_q != 4'hf) hi_q <= hi_q + 4'h1;
   end
   sequence s_req; cyc_i && stb_i && !ack_o; endsequence
   sequence s_ans; ack_o ##1 !ack_o; endsequence
   property p_ack; s_req |=> s_ans; endproperty
   a_ack: assert property (p_ack) else $error("ack missing");
   property p_cause; ack_o |-> $past(cyc_i) && $past(stb_i); endproperty
   a_cause: assert property (p_cause) else $error("stray ack");
   property p_upper; ack_o |-> dat_o[31:8] == 24'h0; endproperty
   a_upper: assert property (p_upper) else $error("upper data");
   property p_dir;
      (scl_c_oe_o || portc_direction_i[0]) && (sda_c_oe_o || portc_direction_i[1]) &&
      (scl_d_oe_o || portd_direction_i[0]) && (sda_d_oe_o || portd_direction_i[1]);
   endproperty
   a_dir: assert property (p_dir) else $error("line not driven");
   property p_low; {scl_c_o, sda_c_o, scl_d_o, sda_d_o} == 4'h0; endproperty
   a_low: assert property (p_low) else $error("pin not low");
   // data may only move while the clock is low, so a long high must see it still
   property p_txs;
      hi_q > 4'h6 && portd_direction_i == 2'b11 && $past(portd_direction_i) == 2'b11 |-> $stable(sda_d_oe_o);
   endproperty
   a_txs: assert property (p_txs) else $error("data moved in high");
   property p_ackl; $rose(sda_d_oe_o) && portd_direction_i[1] && $past(portd_direction_i[1]) |-> !scl_d_i; endproperty
   a_ackl: assert property (p_ackl) else $error("ack in high");
   property p_hold; $rose(scl_d_oe_o) && portd_direction_i[0] && $past(portd_direction_i[0]) |-> !$past(scl_d_i);
   endproperty
   a_hold: assert property (p_hold) else $error("hold in high");
endmodule

// ### sim/twi_master_model.sv
module twi_master_model (
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      scl_oe_o,
   output logic      sda_oe_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // both released at rest: pull-ups keep the lines high between frames
   initial begin
      scl_oe_o = 1'b0;
      sda_oe_o = 1'b0;
   end
   task automatic start();
      sda_oe_o = 1'b1;
      #80 scl_oe_o = 1'b1;
      #40;
   endtask
   // one bit: data set while low, sampled late in the high phase
   task automatic bit_io(input logic b, output logic s);
      sda_oe_o = !b;
      #40 scl_oe_o = 1'b0;
      wait (scl_i === 1'b1);
      #80 s = sda_i;
      scl_oe_o = 1'b1;
      #40;
   endtask
   task automatic xfer(input logic [7:0] d, input logic ma, output logic [7:0] q, output logic ak);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(ma, ak);
   endtask
   task automatic stop();
      sda_oe_o = 1'b1;
      #40 scl_oe_o = 1'b0;
      wait (scl_i === 1'b1);
      #40 sda_oe_o = 1'b0;
      #80;
   endtask
endmodule

// ### sim/tb_two_wire_serial_port.sv
module tb_two_wire_serial_port
   import two_wire_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic             clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [ADR_W-1:0] adr_i = '0;
   logic [3:0]       sel_i = 4'hf;
   logic [DAT_W-1:0] dat_i = '0, dat_o;
   logic [1:0]       portd_direction_i = 2'b11;
   logic             ack_o, irq_o, m_scl, m_sda, ak, scl_d_i, sda_d_i;
   logic             scl_c_oe_o, sda_c_oe_o, scl_d_oe_o, sda_d_oe_o;
   logic [7:0]       v, q;
   int               miscompares = 0, cmp_count = 0;
   // wired-and with pull-ups
   assign scl_d_i = !(m_scl || scl_d_oe_o);
   assign sda_d_i = !(m_sda || sda_d_oe_o);
   always #5 clk_i = !clk_i;
   two_wire_serial_port dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
      .scl_c_i(!scl_c_oe_o), .sda_c_i(!sda_c_oe_o), .scl_d_i, .sda_d_i, .scl_c_o(), .sda_c_o(), .scl_d_o(),
      .sda_d_o(), .scl_c_oe_o, .sda_c_oe_o, .scl_d_oe_o, .sda_d_oe_o, .portc_direction_i(2'b11),
      .portd_direction_i, .irq_o);
   twi_master_model m (.scl_i(scl_d_i), .sda_i(sda_d_i), .scl_oe_o(m_scl), .sda_oe_o(m_sda));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // single cycle, held until ack, wait bounded
   task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= {idx, 2'b00};
      dat_i <= {24'h0, wd};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      if (ack_o !== 1'b1) miscompares++;
      v = dat_o[7:0];
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] idx, input logic [7:0] e);
      wb(1'b0, idx, 8'h00);
      chk(v, e);
   endtask
   task automatic gap();
      repeat (6) @(posedge clk_i);
   endtask
   task automatic t_regs();
      rc(CTL_IDX, 8'h00);
      rc(STAT_IDX, 8'h00);
      rc(8'h20, 8'h00);
      wb(1'b1, OPT_IDX, 8'h10);
      rc(OPT_IDX, 8'h10);
      wb(1'b1, ADDR_IDX, 8'h84);
      wb(1'b1, CTL_IDX, 8'h26);
      wb(1'b1, IRQ_IDX, 8'h02);
   endtask
   task automatic t_rx();
      m.start();
      m.xfer(8'h84, 1'b1, q, ak);
      gap();
      chk({ak, irq_o}, 2'b01);
      rc(STAT_IDX, 8'h09);
      rc(BUF_IDX, 8'h84);
      wb(1'b1, IRQ_IDX, 8'h02);
      m.xfer(8'h5a, 1'b1, q, ak);
      gap();
      chk({ak, irq_o}, 2'b01);
      rc(STAT_IDX, 8'h29);
      wb(1'b1, IRQ_IDX, 8'h02);
      m.xfer(8'ha5, 1'b1, q, ak);
      gap();
      chk({ak, irq_o}, 2'b11);
      rc(CTL_IDX, 8'h66);
      rc(BUF_IDX, 8'h5a);
      wb(1'b1, CTL_IDX, 8'h26);
      rc(CTL_IDX, 8'h26);
      m.stop();
      gap();
      wb(1'b0, STAT_IDX, 8'h00);
      chk({v[4], v[0]}, 2'b10);
   endtask
   task automatic t_tx();
      wb(1'b1, IRQ_IDX, 8'h02);
      m.start();
      m.xfer(8'h85, 1'b1, q, ak);
      gap();
      chk({ak, scl_d_oe_o}, 2'b01);
      wb(1'b0, STAT_IDX, 8'h00);
      chk(v[2:0], 3'b101);
      rc(BUF_IDX, 8'h85);
      fork
         m.xfer(8'hff, 1'b1, q, ak);
         begin
            wb(1'b1, BUF_IDX, 8'hc3);
            wb(1'b1, CTL_IDX, 8'h36);
         end
      join
      gap();
      chk({q, scl_d_oe_o, irq_o}, {8'hc3, 2'b01});
      m.stop();
      m.start();
      m.xfer(8'h90, 1'b1, q, ak);
      gap();
      chk(ak, 1'b1);
      m.stop();
   endtask
   task automatic t_ten();
      wb(1'b1, CTL_IDX, 8'h27);
      wb(1'b1, ADDR_IDX, 8'hf2);
      m.start();
      m.xfer(8'hf2, 1'b1, q, ak);
      gap();
      chk({ak, scl_d_oe_o}, 2'b01);
      rc(STAT_IDX, 8'h0b);
      rc(BUF_IDX, 8'hf2);
      fork
         m.xfer(8'h5c, 1'b1, q, ak);
         wb(1'b1, ADDR_IDX, 8'h5c);
      join
      gap();
      chk({ak, scl_d_oe_o}, 2'b01);
      wb(1'b1, ADDR_IDX, 8'hf2);
      gap();
      chk(scl_d_oe_o, 1'b0);
      m.stop();
   endtask
   task automatic t_master();
      wb(1'b1, CTL_IDX, 8'h2b);
      m.start();
      m.stop();
      gap();
      wb(1'b0, STAT_IDX, 8'h00);
      chk({v[4], irq_o}, 2'b11);
      wb(1'b1, CTL_IDX, 8'h00);
      wb(1'b0, STAT_IDX, 8'h00);
      chk(v[4:3], 2'b00);
      portd_direction_i <= 2'b00;
      gap();
      chk({scl_d_oe_o, sda_d_oe_o}, 2'b11);
      portd_direction_i <= 2'b11;
      gap();
      chk({scl_d_oe_o, sda_d_oe_o}, 2'b00);
   endtask
   task automatic wrap_up();
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_rx();
      t_tx();
      t_ten();
      t_master();
      wrap_up();
   end
   // hang guard, far beyond the few bytes sent
   initial begin
      #200us;
      miscompares++;
      wrap_up();
   end
endmodule
bind two_wire_serial_port twsp_sva sva (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .scl_d_i, .dat_o, .scl_c_o,
   .sda_c_o, .scl_d_o, .sda_d_o, .scl_c_oe_o, .sda_c_oe_o, .scl_d_oe_o, .sda_d_oe_o, .portc_direction_i,
   .portd_direction_i);
